//--- verilog/adc_config_pkg.sv
// constants of the adc configuration and power control register bank
package adc_config_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SOFTWARE_RESET = 8'h00;
  localparam logic [7:0] ADDR_POWER_DOWN_CONTROL = 8'h0F;
  localparam logic [7:0] ADDR_OUTPUT_DRIVE_STRENGTH = 8'h11;
  localparam logic [7:0] ADDR_OUTPUT_FORMAT_CONTROL = 8'h46;
  localparam logic [7:0] ADDR_CONVERTER_PERFORMANCE = 8'h50;
  localparam logic [7:0] ADDR_SERIAL_OUTPUT_CONFIG = 8'h52;
  localparam logic [7:0] ADDR_OUTPUT_TIMING_SHIFT = 8'h53;
  localparam logic [7:0] ADDR_FULL_SCALE_TRIM = 8'h55;
  localparam logic [7:0] ADDR_INPUT_CLOCK_RANGE = 8'h56;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CHANNELS = 8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_SOFT_RESET = 0;
  localparam int POS_LIGHT_SLEEP_LO = 0;
  localparam int POS_DEEP_SLEEP = 8;
  localparam int POS_FULL_POWER_DOWN = 9;
  localparam int POS_PIN_MAP_LO = 10;
  localparam int POS_DRIVE_BIT_CLOCK_LO = 0;
  localparam int POS_DRIVE_FRAME_CLOCK_LO = 4;
  localparam int POS_DRIVE_DATA_LO = 8;
  localparam int POS_TWOS_COMPLEMENT = 2;
  localparam int POS_MSB_FIRST = 3;
  localparam int POS_SDR_ENABLE = 4;
  localparam int POS_SDR_MID_EDGE = 13;
  localparam int POS_PERFORMANCE_LO = 0;
  localparam int POS_VCM_STRENGTH_LO = 4;
  localparam int POS_OUTPUT_SLEEP_BEHAVIOUR = 0;
  localparam int POS_WORD_LENGTH = 1;
  localparam int POS_ADVANCE = 4;
  localparam int POS_DELAY = 5;
  localparam int POS_FULL_SCALE_TRIM_LO = 0;
  localparam int POS_CLOCK_RANGE_LO = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CHANNEL_LIGHT_SLEEP = 8'h00;
  localparam logic [1:0] RST_POWER_PIN_MAPPING = 2'h0;
  localparam logic [2:0] RST_DRIVE_STRENGTH = 3'h0;
  localparam logic [2:0] RST_PERFORMANCE = 3'h0;
  localparam logic [1:0] RST_VCM_STRENGTH = 2'h0;
  localparam logic [5:0] RST_FULL_SCALE_TRIM = 6'h00;
  localparam logic [1:0] RST_CLOCK_RANGE = 2'h0;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // power pin mapping codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PIN_MAP_FULL_POWER_DOWN = 2'h0;
  localparam logic [1:0] PIN_MAP_DEEP_SLEEP = 2'h2;

  // ---------------------------------------------------------------
  // power states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PWR_ACTIVE = 4'h1,
    PWR_LIGHT_SLEEP = 4'h2,
    PWR_DEEP_SLEEP = 4'h4,
    PWR_FULL_DOWN = 4'h8
  } power_state_e;

endpackage

//--- verilog/drive_strength_decode.sv
// decoder from a three-bit drive strength code to current in half milliamps
`timescale 1ns/1ps
module drive_strength_decode
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // code in
  input wire logic [2:0] i_code,
  // current out, units of 0.5 mA
  output logic [3:0] o_half_ma
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // 000..011 give 7,5,3,1 half-mA; 100..111 give 15,13,11,9
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_half_ma <= 4'h7;
    else
      o_half_ma <= {i_code[2], ~i_code[1], ~i_code[0], 1'b1};
  end

endmodule

//--- verilog/adc_config_power_control.sv
// register bank and power mode control of the octal adc
`timescale 1ns/1ps
module adc_config_power_control
#(
  parameter logic [5:0] FULL_SCALE_TRIM_DEFAULT = 6'h00,
  parameter logic [1:0] CLOCK_RANGE_DEFAULT = 2'h0
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // register access port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [adc_config_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [adc_config_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [adc_config_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // power down pin
  input wire logic i_power_down_pin,
  // output format
  output logic o_twos_complement,
  output logic o_msb_first,
  output logic o_sdr_enable,
  output logic o_sdr_mid_edge,
  output logic o_word_length_sel,
  output logic o_advance,
  output logic o_delay,
  // analog trims
  output logic [5:0] o_full_scale_trim_field,
  output logic [2:0] o_performance_control,
  output logic [1:0] o_common_mode_buffer_strength,
  output logic [1:0] o_clock_range,
  // power control
  output adc_config_pkg::power_state_e o_power_state,
  output logic [adc_config_pkg::NUM_CHANNELS-1:0] o_channel_off,
  output logic o_bandgap_enable,
  output logic o_clock_drivers_enable,
  output logic [adc_config_pkg::NUM_CHANNELS-1:0] o_data_drivers_enable,
  output logic [adc_config_pkg::NUM_CHANNELS-1:0] o_data_force_zero,
  // drive strengths in half milliamps
  output logic [3:0] o_bit_clock_drive,
  output logic [3:0] o_frame_clock_drive,
  output logic [3:0] o_data_drive
);
  import adc_config_pkg::*;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [NUM_CHANNELS-1:0] channel_light_sleep;
  logic deep_sleep;
  logic full_power_down;
  logic [1:0] power_pin_mapping;
  logic [2:0] drive_bit_clock;
  logic [2:0] drive_frame_clock;
  logic [2:0] drive_data;
  logic twos_complement;
  logic msb_first;
  logic sdr_enable;
  logic sdr_mid_edge;
  logic [2:0] performance_control;
  logic [1:0] common_mode_buffer_strength;
  logic output_sleep_behaviour;
  logic word_length_sel;
  logic advance;
  logic delay;
  logic [5:0] full_scale_trim_field;
  logic [1:0] clock_range;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  logic soft_reset;
  logic init;
  logic wr_power;
  logic wr_drive;
  logic wr_format;
  logic wr_perf;
  logic wr_serial;
  logic wr_shift;
  logic wr_trim;
  logic wr_clock;

  assign soft_reset = i_reg_wr && (i_reg_addr == ADDR_SOFTWARE_RESET)
                      && i_reg_wdata[POS_SOFT_RESET];
  assign init = i_reset || soft_reset;
  assign wr_power = i_reg_wr && (i_reg_addr == ADDR_POWER_DOWN_CONTROL);
  assign wr_drive = i_reg_wr && (i_reg_addr == ADDR_OUTPUT_DRIVE_STRENGTH);
  assign wr_format = i_reg_wr && (i_reg_addr == ADDR_OUTPUT_FORMAT_CONTROL);
  assign wr_perf = i_reg_wr && (i_reg_addr == ADDR_CONVERTER_PERFORMANCE);
  assign wr_serial = i_reg_wr && (i_reg_addr == ADDR_SERIAL_OUTPUT_CONFIG);
  assign wr_shift = i_reg_wr && (i_reg_addr == ADDR_OUTPUT_TIMING_SHIFT);
  assign wr_trim = i_reg_wr && (i_reg_addr == ADDR_FULL_SCALE_TRIM);
  assign wr_clock = i_reg_wr && (i_reg_addr == ADDR_INPUT_CLOCK_RANGE);

  // ---------------------------------------------------------------
  // power down control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
    begin
      channel_light_sleep <= RST_CHANNEL_LIGHT_SLEEP;
      deep_sleep <= 1'b0;
      full_power_down <= 1'b0;
      power_pin_mapping <= RST_POWER_PIN_MAPPING;
    end
    else if (wr_power)
    begin
      channel_light_sleep <= i_reg_wdata[POS_LIGHT_SLEEP_LO +: NUM_CHANNELS];
      deep_sleep <= i_reg_wdata[POS_DEEP_SLEEP];
      full_power_down <= i_reg_wdata[POS_FULL_POWER_DOWN];
      power_pin_mapping <= i_reg_wdata[POS_PIN_MAP_LO +: 2];
    end
  end

  // ---------------------------------------------------------------
  // drive strength register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
    begin
      drive_bit_clock <= RST_DRIVE_STRENGTH;
      drive_frame_clock <= RST_DRIVE_STRENGTH;
      drive_data <= RST_DRIVE_STRENGTH;
    end
    else if (wr_drive)
    begin
      drive_bit_clock <= i_reg_wdata[POS_DRIVE_BIT_CLOCK_LO +: 3];
      drive_frame_clock <= i_reg_wdata[POS_DRIVE_FRAME_CLOCK_LO +: 3];
      drive_data <= i_reg_wdata[POS_DRIVE_DATA_LO +: 3];
    end
  end

  // ---------------------------------------------------------------
  // output format register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
    begin
      twos_complement <= 1'b0;
      msb_first <= 1'b0;
      sdr_enable <= 1'b0;
      sdr_mid_edge <= 1'b0;
    end
    else if (wr_format)
    begin
      twos_complement <= i_reg_wdata[POS_TWOS_COMPLEMENT];
      msb_first <= i_reg_wdata[POS_MSB_FIRST];
      sdr_enable <= i_reg_wdata[POS_SDR_ENABLE];
      sdr_mid_edge <= i_reg_wdata[POS_SDR_MID_EDGE];
    end
  end

  // ---------------------------------------------------------------
  // converter performance register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
    begin
      performance_control <= RST_PERFORMANCE;
      common_mode_buffer_strength <= RST_VCM_STRENGTH;
    end
    else if (wr_perf)
    begin
      performance_control <= i_reg_wdata[POS_PERFORMANCE_LO +: 3];
      common_mode_buffer_strength <= i_reg_wdata[POS_VCM_STRENGTH_LO +: 2];
    end
  end

  // ---------------------------------------------------------------
  // serial output configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
    begin
      output_sleep_behaviour <= 1'b0;
      word_length_sel <= 1'b0;
    end
    else if (wr_serial)
    begin
      output_sleep_behaviour <= i_reg_wdata[POS_OUTPUT_SLEEP_BEHAVIOUR];
      word_length_sel <= i_reg_wdata[POS_WORD_LENGTH];
    end
  end

  // ---------------------------------------------------------------
  // timing shift register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
    begin
      advance <= 1'b0;
      delay <= 1'b0;
    end
    else if (wr_shift)
    begin
      advance <= i_reg_wdata[POS_ADVANCE];
      delay <= i_reg_wdata[POS_DELAY];
    end
  end

  // ---------------------------------------------------------------
  // full scale trim and clock range registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (init)
      full_scale_trim_field <= FULL_SCALE_TRIM_DEFAULT;
    else if (wr_trim)
      full_scale_trim_field <= i_reg_wdata[POS_FULL_SCALE_TRIM_LO +: 6];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (init)
      clock_range <= CLOCK_RANGE_DEFAULT;
    else if (wr_clock)
      clock_range <= i_reg_wdata[POS_CLOCK_RANGE_LO +: 2];
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] read_word;

  always_comb
  begin
    read_word = READ_ZERO;
    if (i_reg_addr == ADDR_POWER_DOWN_CONTROL)
    begin
      read_word[POS_LIGHT_SLEEP_LO +: NUM_CHANNELS] = channel_light_sleep;
      read_word[POS_DEEP_SLEEP] = deep_sleep;
      read_word[POS_FULL_POWER_DOWN] = full_power_down;
      read_word[POS_PIN_MAP_LO +: 2] = power_pin_mapping;
    end
    else if (i_reg_addr == ADDR_OUTPUT_DRIVE_STRENGTH)
    begin
      read_word[POS_DRIVE_BIT_CLOCK_LO +: 3] = drive_bit_clock;
      read_word[POS_DRIVE_FRAME_CLOCK_LO +: 3] = drive_frame_clock;
      read_word[POS_DRIVE_DATA_LO +: 3] = drive_data;
    end
    else if (i_reg_addr == ADDR_OUTPUT_FORMAT_CONTROL)
    begin
      read_word[POS_TWOS_COMPLEMENT] = twos_complement;
      read_word[POS_MSB_FIRST] = msb_first;
      read_word[POS_SDR_ENABLE] = sdr_enable;
      read_word[POS_SDR_MID_EDGE] = sdr_mid_edge;
    end
    else if (i_reg_addr == ADDR_CONVERTER_PERFORMANCE)
    begin
      read_word[POS_PERFORMANCE_LO +: 3] = performance_control;
      read_word[POS_VCM_STRENGTH_LO +: 2] = common_mode_buffer_strength;
    end
    else if (i_reg_addr == ADDR_SERIAL_OUTPUT_CONFIG)
    begin
      read_word[POS_OUTPUT_SLEEP_BEHAVIOUR] = output_sleep_behaviour;
      read_word[POS_WORD_LENGTH] = word_length_sel;
    end
    else if (i_reg_addr == ADDR_OUTPUT_TIMING_SHIFT)
    begin
      read_word[POS_ADVANCE] = advance;
      read_word[POS_DELAY] = delay;
    end
    else if (i_reg_addr == ADDR_FULL_SCALE_TRIM)
      read_word[POS_FULL_SCALE_TRIM_LO +: 6] = full_scale_trim_field;
    else if (i_reg_addr == ADDR_INPUT_CLOCK_RANGE)
      read_word[POS_CLOCK_RANGE_LO +: 2] = clock_range;
  end

  // software reset bit and unmapped offsets read as zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= READ_ZERO;
      o_reg_rd_valid <= 1'b0;
    end
    else
    begin
      o_reg_rd_valid <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata <= read_word;
    end
  end

  // ---------------------------------------------------------------
  // power down pin synchroniser
  // ---------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= i_power_down_pin;
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // requested power state
  // ---------------------------------------------------------------
  logic req_full;
  logic req_deep;
  logic [NUM_CHANNELS-1:0] req_light;
  power_state_e next_power_state;
  logic [NUM_CHANNELS-1:0] next_channel_off;

  assign req_full = full_power_down
                    || (pin_sync && power_pin_mapping == PIN_MAP_FULL_POWER_DOWN);
  assign req_deep = deep_sleep
                    || (pin_sync && power_pin_mapping == PIN_MAP_DEEP_SLEEP);
  assign req_light = channel_light_sleep
                     | {NUM_CHANNELS{pin_sync && power_pin_mapping[0]}};

  always_comb
  begin
    next_power_state = PWR_ACTIVE;
    next_channel_off = '0;
    if (req_full)
    begin
      next_power_state = PWR_FULL_DOWN;
      next_channel_off = '1;
    end
    else if (req_deep)
    begin
      next_power_state = PWR_DEEP_SLEEP;
      next_channel_off = '1;
    end
    else if (req_light != '0)
    begin
      next_power_state = PWR_LIGHT_SLEEP;
      next_channel_off = req_light;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_power_state <= PWR_ACTIVE;
      o_channel_off <= '0;
      o_bandgap_enable <= 1'b1;
      o_clock_drivers_enable <= 1'b1;
    end
    else
    begin
      o_power_state <= next_power_state;
      o_channel_off <= next_channel_off;
      o_bandgap_enable <= !req_full;
      o_clock_drivers_enable <= !req_full;
    end
  end

  // ---------------------------------------------------------------
  // data output drivers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_data_drivers_enable <= '1;
      o_data_force_zero <= '0;
    end
    else if (req_full)
    begin
      o_data_drivers_enable <= '0;
      o_data_force_zero <= '0;
    end
    else if (output_sleep_behaviour)
    begin
      o_data_drivers_enable <= '1;
      o_data_force_zero <= next_channel_off;
    end
    else
    begin
      o_data_drivers_enable <= ~next_channel_off;
      o_data_force_zero <= '0;
    end
  end

  // ---------------------------------------------------------------
  // format and trim outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_twos_complement <= 1'b0;
      o_msb_first <= 1'b0;
      o_sdr_enable <= 1'b0;
      o_sdr_mid_edge <= 1'b0;
      o_word_length_sel <= 1'b0;
      o_advance <= 1'b0;
      o_delay <= 1'b0;
    end
    else
    begin
      o_twos_complement <= twos_complement;
      o_msb_first <= msb_first;
      o_sdr_enable <= sdr_enable;
      o_sdr_mid_edge <= sdr_enable && sdr_mid_edge;
      o_word_length_sel <= word_length_sel;
      o_advance <= advance && !delay;
      o_delay <= delay && !advance;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_full_scale_trim_field <= FULL_SCALE_TRIM_DEFAULT;
      o_performance_control <= RST_PERFORMANCE;
      o_common_mode_buffer_strength <= RST_VCM_STRENGTH;
      o_clock_range <= CLOCK_RANGE_DEFAULT;
    end
    else
    begin
      o_full_scale_trim_field <= full_scale_trim_field;
      o_performance_control <= performance_control;
      o_common_mode_buffer_strength <= common_mode_buffer_strength;
      o_clock_range <= clock_range;
    end
  end

  // ---------------------------------------------------------------
  // drive strength decoders
  // ---------------------------------------------------------------
  drive_strength_decode u_bit_clock_drive
  (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_code(drive_bit_clock),
    .o_half_ma(o_bit_clock_drive)
  );

  drive_strength_decode u_frame_clock_drive
  (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_code(drive_frame_clock),
    .o_half_ma(o_frame_clock_drive)
  );

  drive_strength_decode u_data_drive
  (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_code(drive_data),
    .o_half_ma(o_data_drive)
  );

endmodule

//--- test/adc_cfg_checker.sv
// assertions on the register bank and power state outputs
`timescale 1ns/1ps
module adc_cfg_checker
#(
  parameter logic [5:0] FULL_SCALE_TRIM_DEFAULT = 6'h00
)
(
  // clock, reset and register port
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_reg_wr,
  input wire logic [adc_config_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [adc_config_pkg::DATA_W-1:0] i_reg_wdata,
  // watched outputs
  input wire logic o_twos_complement,
  input wire logic o_msb_first,
  input wire logic o_sdr_enable,
  input wire logic o_sdr_mid_edge,
  input wire logic o_advance,
  input wire logic o_delay,
  input wire logic [5:0] o_full_scale_trim_field,
  input wire adc_config_pkg::power_state_e o_power_state,
  input wire logic [7:0] o_channel_off,
  input wire logic o_bandgap_enable,
  input wire logic o_clock_drivers_enable,
  input wire logic [7:0] o_data_drivers_enable,
  input wire logic [7:0] o_data_force_zero,
  input wire logic [3:0] o_bit_clock_drive,
  input wire logic [3:0] o_frame_clock_drive,
  input wire logic [3:0] o_data_drive
);
  import adc_config_pkg::*;
  logic wr_fmt;
  logic wr_drv;
  logic wr_trim;
  logic soft_rst;
  assign wr_fmt = i_reg_wr && i_reg_addr == ADDR_OUTPUT_FORMAT_CONTROL;
  assign wr_drv = i_reg_wr && i_reg_addr == ADDR_OUTPUT_DRIVE_STRENGTH;
  assign wr_trim = i_reg_wr && i_reg_addr == ADDR_FULL_SCALE_TRIM;
  assign soft_rst = i_reg_wr && i_reg_addr == ADDR_SOFTWARE_RESET && i_reg_wdata[0];
  function automatic logic [3:0] half_ma(input logic [2:0] c);
    return (c[2] ? 4'hF : 4'h7) - {1'b0, c[1:0], 1'b0};
  endfunction
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_format_follows_write:
  assert property (wr_fmt ##1 !(wr_fmt || soft_rst) |-> ##1 o_twos_complement == $past(i_reg_wdata[2], 2)
    && o_msb_first == $past(i_reg_wdata[3], 2) && o_sdr_enable == $past(i_reg_wdata[4], 2)
    && o_sdr_mid_edge == ($past(i_reg_wdata[13], 2) && $past(i_reg_wdata[4], 2)))
    else $error("format outputs differ from write");
  a_trim_follows_write:
  assert property (wr_trim ##1 !(wr_trim || soft_rst) |-> ##1 o_full_scale_trim_field == $past(i_reg_wdata[5:0], 2))
    else $error("trim differs from write");
  a_drive_code_decode:
  assert property (wr_drv ##1 !(wr_drv || soft_rst) |-> ##1 o_bit_clock_drive == half_ma($past(i_reg_wdata[2:0], 2))
    && o_frame_clock_drive == half_ma($past(i_reg_wdata[6:4], 2)) && o_data_drive == half_ma($past(i_reg_wdata[10:8], 2)))
    else $error("drive strength decode wrong");
  a_soft_reset_defaults:
  assert property (soft_rst ##1 !i_reg_wr |-> ##1 !o_twos_complement && !o_msb_first && !o_sdr_enable
    && o_full_scale_trim_field == FULL_SCALE_TRIM_DEFAULT && o_bit_clock_drive == 4'h7)
    else $error("software reset left a field set");
  a_shift_not_both:
  assert property (!(o_advance && o_delay))
    else $error("advance and delay both active");
  a_full_down_off:
  assert property (o_power_state == PWR_FULL_DOWN |-> !o_bandgap_enable && !o_clock_drivers_enable
    && o_data_drivers_enable == 8'h00 && o_channel_off == 8'hFF)
    else $error("full power down outputs wrong");
  a_sleep_clocks_on:
  assert property (o_power_state inside {PWR_LIGHT_SLEEP, PWR_DEEP_SLEEP} |-> o_clock_drivers_enable
    && (o_power_state != PWR_DEEP_SLEEP || o_channel_off == 8'hFF))
    else $error("sleep clock drivers or channels wrong");
  a_sleep_data_drivers:
  assert property (o_power_state != PWR_FULL_DOWN |-> o_data_force_zero == (o_data_drivers_enable & o_channel_off)
    && (o_data_drivers_enable | o_channel_off) == 8'hFF)
    else $error("data drivers wrong in sleep");
  c_light: cover property (o_power_state == PWR_LIGHT_SLEEP);
  c_deep: cover property (o_power_state == PWR_DEEP_SLEEP);
  c_full: cover property (o_power_state == PWR_FULL_DOWN);
endmodule

//--- test/adc_host_model.sv
// host model issuing register writes and reads from the falling edge
`timescale 1ns/1ps
module adc_host_model
(
  // clock and answers
  input wire logic i_ref_clk,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rd_valid,
  // requests
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_reg_wdata
);
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 16'h0000;
  end
  // one request held across one rising edge; read data taken while valid stands
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(negedge i_ref_clk);
    o_reg_wr = w;
    o_reg_rd = r;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_ref_clk);
    q = (i_reg_rd_valid === 1'b1) ? i_reg_rdata : 16'hXXXX;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
endmodule

//--- test/adc_config_power_control_tb.sv
// self-checking bench of the register bank and power control
`timescale 1ns/1ps
module adc_config_power_control_tb;
  import adc_config_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic p; logic [15:0] r; logic [27:0] c; logic [31:0] w;} row_s;
  localparam logic [31:0] ACT = 32'h1300FF00;
  localparam logic [31:0] CFG0 = 32'h07770000;
  row_s rows [27] = '{
    '{8'h46,16'h0004,1'b0,16'h0004,28'h7770040,ACT},
    '{8'h46,16'h201C,1'b0,16'h201C,28'h7770078,ACT},
    '{8'h46,16'h2008,1'b0,16'h2008,28'h7770020,ACT},
    '{8'h52,16'h0002,1'b0,16'h0002,28'h7770024,ACT},
    '{8'h53,16'h0010,1'b0,16'h0010,28'h7770026,ACT},
    '{8'h53,16'h0020,1'b0,16'h0020,28'h7770025,ACT},
    '{8'h53,16'h0030,1'b0,16'h0030,28'h7770024,ACT},
    '{8'h55,16'hFFFF,1'b0,16'h003F,28'h7773F24,ACT},
    '{8'h11,16'h0123,1'b0,16'h0123,28'h1353F24,ACT},
    '{8'h11,16'h0764,1'b0,16'h0764,28'hFB93F24,ACT},
    '{8'h11,16'h0555,1'b0,16'h0555,28'hDDD3F24,ACT},
    '{8'h50,16'h0037,1'b0,16'h0037,28'hDDD3F24,ACT},
    '{8'h56,16'hFFFF,1'b0,16'h0003,28'hDDD3F24,ACT},
    '{8'h20,16'hFFFF,1'b0,16'h0000,28'hDDD3F24,ACT},
    '{8'h00,16'hFFFE,1'b0,16'h0000,28'hDDD3F24,ACT},
    '{8'h0F,16'h0005,1'b0,16'h0005,28'hDDD3F24,32'h2305FA00},
    '{8'h52,16'h0001,1'b0,16'h0001,28'hDDD3F20,32'h2305FF05},
    '{8'h0F,16'h0100,1'b0,16'h0100,28'hDDD3F20,32'h43FFFFFF},
    '{8'h0F,16'h0300,1'b0,16'h0300,28'hDDD3F20,32'h80FF0000},
    '{8'h0F,16'h0000,1'b1,16'h0000,28'hDDD3F20,32'h80FF0000},
    '{8'h0F,16'h0800,1'b1,16'h0800,28'hDDD3F20,32'h43FFFFFF},
    '{8'h0F,16'h0400,1'b1,16'h0400,28'hDDD3F20,32'h23FFFFFF},
    '{8'h0F,16'h0C00,1'b1,16'h0C00,28'hDDD3F20,32'h23FFFFFF},
    '{8'h52,16'h0000,1'b1,16'h0000,28'hDDD3F20,32'h23FF0000},
    '{8'h0F,16'h0600,1'b1,16'h0600,28'hDDD3F20,32'h80FF0000},
    '{8'h0F,16'h0000,1'b0,16'h0000,28'hDDD3F20,ACT},
    '{8'h00,16'h0001,1'b0,16'h0000,28'h7770000,ACT}};
  logic [7:0] regs [9] = '{8'h00, 8'h0F, 8'h11, 8'h46, 8'h50, 8'h52, 8'h53, 8'h55, 8'h56};
  logic i_ref_clk = 1'b0;
  logic i_reset, i_power_down_pin, i_reg_wr, i_reg_rd, o_reg_rd_valid, o_twos_complement, o_msb_first;
  logic o_sdr_enable, o_sdr_mid_edge, o_word_length_sel, o_advance, o_delay, o_bandgap_enable, o_clock_drivers_enable;
  logic [7:0] i_reg_addr, o_channel_off, o_data_drivers_enable, o_data_force_zero;
  logic [15:0] i_reg_wdata, o_reg_rdata, q;
  logic [5:0] o_full_scale_trim_field;
  logic [3:0] o_bit_clock_drive, o_frame_clock_drive, o_data_drive;
  logic [2:0] o_performance_control;
  logic [1:0] o_common_mode_buffer_strength, o_clock_range;
  power_state_e o_power_state;
  logic [31:0] cfg_seen, pwr_seen;
  int cycles = 0;
  int n_errors = 0;
  int samples_checked = 0;
  assign cfg_seen = {4'h0, o_bit_clock_drive, o_frame_clock_drive, o_data_drive, 2'h0, o_full_scale_trim_field,
    1'b0, o_twos_complement, o_msb_first, o_sdr_enable, o_sdr_mid_edge, o_word_length_sel, o_advance, o_delay};
  assign pwr_seen = {o_power_state, 2'h0, o_bandgap_enable, o_clock_drivers_enable, o_channel_off,
    o_data_drivers_enable, o_data_force_zero};
  adc_config_power_control dut (.*);
  adc_host_model host (.i_ref_clk(i_ref_clk), .i_reg_rdata(o_reg_rdata), .i_reg_rd_valid(o_reg_rd_valid),
    .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  always #20 i_ref_clk = ~i_ref_clk;
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    i_reset = 1'b1;
    i_power_down_pin = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    i_reset = 1'b0;
    chk("reset cfg", CFG0, cfg_seen);
    chk("reset power", ACT, pwr_seen);
    foreach (regs[k])
    begin
      host.access(1'b0, 1'b1, regs[k], 16'h0000, q);
      chk("reset read", 32'h00000000, {16'h0000, q});
    end
    foreach (rows[k])
    begin
      i_power_down_pin = rows[k].p;
      host.access(1'b1, 1'b0, rows[k].a, rows[k].d, q);
      repeat (4) @(negedge i_ref_clk);
      chk("cfg", {4'h0, rows[k].c}, cfg_seen);
      chk("power", rows[k].w, pwr_seen);
      if (rows[k].a == 8'h56)
        chk("analog", 32'h7F, {o_clock_range, o_common_mode_buffer_strength, o_performance_control});
      host.access(1'b0, 1'b1, rows[k].a, 16'h0000, q);
      chk("readback", {16'h0000, rows[k].r}, {16'h0000, q});
    end
    host.access(1'b1, 1'b0, 8'h46, 16'h001C, q);
    host.access(1'b1, 1'b1, 8'h55, 16'h002A, q);
    chk("read beside write", 32'h00000000, {16'h0000, q});
    host.access(1'b0, 1'b1, 8'h55, 16'h0000, q);
    chk("trim read", 32'h0000002A, {16'h0000, q});
    chk("format", 32'h07772A70, cfg_seen);
    i_reset = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 1'b0;
    @(negedge i_ref_clk);
    chk("after reset", CFG0, cfg_seen);
    results();
  end
endmodule
bind adc_config_power_control adc_cfg_checker #(.FULL_SCALE_TRIM_DEFAULT(FULL_SCALE_TRIM_DEFAULT)) u_chk (.*);
